// ### inc/flash_seq_pkg.sv
package flash_seq_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 250;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_VERIFY = 8'hC0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 18'h00000;
  localparam logic [ADDR_W-1:0] ID_PART_ADDR = 18'h00001;
  // Wait times in their own units
  localparam int ERASE_WAIT_MS = 10;
  localparam int PROGRAM_WAIT_US = 10;
  localparam int ERASE_WAIT_CYC = ERASE_WAIT_MS * 1000 * CLK_MHZ;
  localparam int PROGRAM_WAIT_CYC = PROGRAM_WAIT_US * CLK_MHZ;
  // Bus strobe phase lengths, in cycles
  localparam int STROBE_CYC = 25;
  localparam int SETTLE_CYC = 40;
  localparam int CNT_W = 32;
  localparam int MAX_ERASE_PULSES = 1000;
  localparam int MAX_PROGRAM_PULSES = 25;

  typedef enum logic [1:0]
  {
    OP_PROGRAM = 2'h0,
    OP_ERASE   = 2'h1,
    OP_IDENT   = 2'h2
  } op_e;

  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              chipSelN;
    logic              outEnN;
    logic              writeN;
    logic              dataOe;
  } flash_bus_s;
endpackage

// ### rtl/flash_command_sequencer.sv
`timescale 1ns/1ps
module flash_command_sequencer #(
  parameter int ADDR_W       = flash_seq_pkg::ADDR_W,
  parameter int ERASE_WAIT   = flash_seq_pkg::ERASE_WAIT_CYC,
  parameter int PROGRAM_WAIT = flash_seq_pkg::PROGRAM_WAIT_CYC,
  parameter int LAST_ADDR    = 262143
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     start,
  input  wire flash_seq_pkg::op_e       op,
  input  wire logic [ADDR_W-1:0]        opAddr,
  input  wire logic [7:0]               opData,
  input  wire logic                     programSupplyHigh,
  input  wire logic [7:0]               dataLinesIn,
  output flash_seq_pkg::flash_bus_s     bus,
  output logic                          busy,
  output logic                          done,
  output logic                          fail,
  output logic [7:0]                    makerId,
  output logic [7:0]                    partId
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins

  logic [7:0] dataMeta;
  logic [7:0] dataSync;
  logic       supplyMeta;
  logic       supplySync;

  always_ff @(posedge clk)
  begin
    dataMeta   <= dataLinesIn;
    dataSync   <= dataMeta;
    supplyMeta <= programSupplyHigh;
    supplySync <= supplyMeta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  typedef enum logic [3:0]
  {
    S_IDLE    = 4'h0,
    S_CMD1    = 4'h1,
    S_CMD2    = 4'h3,
    S_WAIT    = 4'h2,
    S_VERIFY  = 4'h6,
    S_READ    = 4'h7,
    S_CHECK   = 4'h5,
    S_FINISH  = 4'h4,
    S_ZERO    = 4'hC
  } state_e;

  state_e                       state;
  state_e                       next_state;
  flash_seq_pkg::op_e           curOp;
  flash_seq_pkg::op_e           next_curOp;
  logic [ADDR_W-1:0]            addr;
  logic [ADDR_W-1:0]            next_addr;
  logic [7:0]                   data;
  logic [7:0]                   next_data;
  logic [flash_seq_pkg::CNT_W-1:0] cnt;
  logic [flash_seq_pkg::CNT_W-1:0] next_cnt;
  logic [15:0]                  tries;
  logic [15:0]                  next_tries;
  logic                         zeroPass;
  logic                         next_zeroPass;
  flash_seq_pkg::flash_bus_s    next_bus;
  logic                         next_done;
  logic                         next_fail;
  logic [7:0]                   next_makerId;
  logic [7:0]                   next_partId;
  logic [7:0]                   cmd1;
  logic [7:0]                   cmd2;
  logic                         phaseLow;
  logic                         phaseEnd;

  assign busy = (state != S_IDLE);
  assign phaseLow = (cnt < flash_seq_pkg::STROBE_CYC);
  assign phaseEnd = (cnt == flash_seq_pkg::SETTLE_CYC);

  always_comb
  begin
    cmd1 = flash_seq_pkg::CMD_READ;
    cmd2 = flash_seq_pkg::CMD_READ;
    case (curOp)
      flash_seq_pkg::OP_ERASE:
      begin
        cmd1 = flash_seq_pkg::CMD_ERASE;
        cmd2 = flash_seq_pkg::CMD_ERASE;
      end
      flash_seq_pkg::OP_IDENT:
        cmd1 = flash_seq_pkg::CMD_IDENT;
      default:
      begin
        cmd1 = flash_seq_pkg::CMD_PROGRAM;
        cmd2 = data;
      end
    endcase
    if (zeroPass)
    begin
      cmd1 = flash_seq_pkg::CMD_PROGRAM;
      cmd2 = flash_seq_pkg::ZERO_BYTE;
    end
  end

  always_comb
  begin
    next_state    = state;
    next_curOp    = curOp;
    next_addr     = addr;
    next_data     = data;
    next_cnt      = cnt + 1'b1;
    next_tries    = tries;
    next_zeroPass = zeroPass;
    next_done     = 1'b0;
    next_fail     = fail;
    next_makerId  = makerId;
    next_partId   = partId;
    next_bus      = bus;
    next_bus.chipSelN = 1'b1;
    next_bus.outEnN   = 1'b1;
    next_bus.writeN   = 1'b1;
    next_bus.dataOe   = 1'b0;
    case (state)
      S_IDLE:
      begin
        next_cnt = '0;
        if (start && supplySync)
        begin
          next_curOp    = op;
          next_addr     = (op == flash_seq_pkg::OP_PROGRAM) ? opAddr :
                          ((op == flash_seq_pkg::OP_IDENT) ? flash_seq_pkg::ID_MAKER_ADDR : '0);
          next_data     = opData;
          next_tries    = '0;
          next_fail     = 1'b0;
          next_zeroPass = (op == flash_seq_pkg::OP_ERASE);
          next_state    = S_CMD1;
        end
      end
      S_CMD1:
      begin
        // Chip select low, strobe low then high; data held past the rise
        next_bus.chipSelN = 1'b0;
        next_bus.writeN   = !phaseLow;
        next_bus.dataOe   = 1'b1;
        next_bus.data     = cmd1;
        if (phaseEnd)
        begin
          next_cnt   = '0;
          next_state = (curOp == flash_seq_pkg::OP_IDENT) ? S_READ : S_CMD2;
        end
      end
      S_CMD2:
      begin
        // Address driven on the same edge as the fall, data stable through rise
        next_bus.chipSelN = 1'b0;
        next_bus.writeN   = !phaseLow;
        next_bus.dataOe   = 1'b1;
        next_bus.data     = cmd2;
        next_bus.addr     = addr;
        if (phaseEnd)
        begin
          next_cnt   = '0;
          next_state = S_WAIT;
        end
      end
      S_WAIT:
      begin
        if (cnt == ((zeroPass || curOp == flash_seq_pkg::OP_PROGRAM) ?
            PROGRAM_WAIT : ERASE_WAIT))
        begin
          next_cnt   = '0;
          next_state = S_VERIFY;
        end
      end
      S_VERIFY:
      begin
        // Verify strobe ends the pulse and latches the address
        next_bus.chipSelN = 1'b0;
        next_bus.writeN   = !phaseLow;
        next_bus.dataOe   = 1'b1;
        next_bus.addr     = addr;
        next_bus.data     = (curOp == flash_seq_pkg::OP_ERASE && !zeroPass) ?
                            flash_seq_pkg::CMD_ERASE_VERIFY : flash_seq_pkg::CMD_PROGRAM_VERIFY;
        if (phaseEnd)
        begin
          next_cnt   = '0;
          next_state = S_READ;
        end
      end
      S_READ:
      begin
        // Verify or identifier mode persists; read strobe only
        next_bus.chipSelN = 1'b0;
        next_bus.outEnN   = 1'b0;
        next_bus.addr     = addr;
        if (phaseEnd)
        begin
          next_cnt   = '0;
          next_state = S_CHECK;
        end
      end
      S_CHECK:
      begin
        next_cnt   = '0;
        next_state = S_CMD1;
        if (curOp == flash_seq_pkg::OP_IDENT)
        begin
          if (addr == flash_seq_pkg::ID_MAKER_ADDR)
          begin
            next_makerId = dataSync;
            next_addr    = flash_seq_pkg::ID_PART_ADDR;
            next_state   = S_READ;
          end
          else
          begin
            next_partId = dataSync;
            next_state  = S_FINISH;
          end
        end
        else if (dataSync == (zeroPass ? flash_seq_pkg::ZERO_BYTE :
                 ((curOp == flash_seq_pkg::OP_ERASE) ? flash_seq_pkg::ERASED_BYTE : data)))
        begin
          next_tries = '0;
          if (curOp == flash_seq_pkg::OP_PROGRAM)
            next_state = S_FINISH;
          else if (addr == ADDR_W'(LAST_ADDR))
          begin
            next_addr     = '0;
            next_zeroPass = 1'b0;
            next_state    = zeroPass ? S_CMD1 : S_FINISH;
          end
          else
          begin
            next_addr  = addr + 1'b1;
            next_state = zeroPass ? S_CMD1 : S_VERIFY;
          end
        end
        else
        begin
          // Retry: another pulse, verify resumes at the failing byte
          next_tries = tries + 1'b1;
          if (tries + 1'b1 == 16'((zeroPass || curOp == flash_seq_pkg::OP_PROGRAM) ?
              flash_seq_pkg::MAX_PROGRAM_PULSES : flash_seq_pkg::MAX_ERASE_PULSES))
          begin
            next_fail  = 1'b1;
            next_state = S_ZERO;
          end
        end
      end
      S_ZERO:
      begin
        // Return to read mode; two FFh cancel any set-up
        next_bus.chipSelN = 1'b0;
        next_bus.writeN   = !(phaseLow || (cnt >= flash_seq_pkg::SETTLE_CYC &&
                            cnt < flash_seq_pkg::SETTLE_CYC + flash_seq_pkg::STROBE_CYC));
        next_bus.dataOe   = 1'b1;
        next_bus.data     = flash_seq_pkg::CMD_RESET;
        if (cnt == 2 * flash_seq_pkg::SETTLE_CYC)
        begin
          next_cnt   = '0;
          next_state = S_FINISH;
        end
      end
      S_FINISH:
      begin
        // Leave flash in read mode afterwards
        next_bus.chipSelN = 1'b0;
        next_bus.writeN   = !phaseLow;
        next_bus.dataOe   = 1'b1;
        next_bus.data     = flash_seq_pkg::CMD_READ;
        if (phaseEnd)
        begin
          next_done  = 1'b1;
          next_state = S_IDLE;
        end
      end
      default:
        next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state    <= S_IDLE;
      curOp    <= flash_seq_pkg::OP_PROGRAM;
      addr     <= '0;
      data     <= 8'h00;
      cnt      <= '0;
      tries    <= 16'h0000;
      zeroPass <= 1'b0;
      done     <= 1'b0;
      fail     <= 1'b0;
      makerId  <= 8'h00;
      partId   <= 8'h00;
      bus      <= '{addr: '0, data: 8'h00, chipSelN: 1'b1, outEnN: 1'b1,
                    writeN: 1'b1, dataOe: 1'b0};
    end
    else
    begin
      state    <= next_state;
      curOp    <= next_curOp;
      addr     <= next_addr;
      data     <= next_data;
      cnt      <= next_cnt;
      tries    <= next_tries;
      zeroPass <= next_zeroPass;
      done     <= next_done;
      fail     <= next_fail;
      makerId  <= next_makerId;
      partId   <= next_partId;
      bus      <= next_bus;
    end
  end

endmodule // flash_command_sequencer

// ### tb/flash_seq_properties.sv
`timescale 1ns/1ps
module flash_seq_properties #(
  parameter int ADDR_W       = 18,
  parameter int PROGRAM_WAIT = 2500
) (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       start,
  input wire flash_seq_pkg::op_e         op,
  input wire logic [ADDR_W-1:0]          opAddr,
  input wire logic [7:0]                 opData,
  input wire logic                       programSupplyHigh,
  input wire logic [7:0]                 dataLinesIn,
  input wire flash_seq_pkg::flash_bus_s  bus,
  input wire logic                       busy,
  input wire logic                       done,
  input wire logic                       fail,
  input wire logic [7:0]                 makerId,
  input wire logic [7:0]                 partId
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  int lowCnt;
  int gap;
  int next_lowCnt;
  int next_gap;
  always_comb
  begin
    next_lowCnt = bus.writeN ? 0 : lowCnt + 1;
    next_gap    = bus.writeN ? gap + 1 : 0;
  end
  always_ff @(posedge clk)
  begin
    lowCnt <= rst ? 0 : next_lowCnt;
    gap    <= rst ? 0 : next_gap;
  end
  ////////////////////////////////////////
  property p_idle_bus;
    !busy ##1 !busy |-> bus.chipSelN && bus.writeN && bus.outEnN && !bus.dataOe;
  endproperty
  a_idle_bus: assert property (p_idle_bus) else $error("bus active while idle");
  property p_write_sel;
    !bus.writeN |-> !bus.chipSelN && bus.outEnN && bus.dataOe;
  endproperty
  a_write_sel: assert property (p_write_sel) else $error("bad write select");
  property p_read_sel;
    !bus.outEnN |-> bus.writeN && !bus.dataOe && !bus.chipSelN;
  endproperty
  a_read_sel: assert property (p_read_sel) else $error("bad read select");
  property p_strobe_len;
    $rose(bus.writeN) |-> lowCnt == 25;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe width");
  property p_hold;
    !bus.writeN && $past(!bus.writeN) |-> $stable(bus.addr) && $stable(bus.data);
  endproperty
  a_hold: assert property (p_hold) else $error("bus moved in strobe");
  property p_verify_gap;
    $fell(bus.writeN) && bus.data == flash_seq_pkg::CMD_PROGRAM_VERIFY |-> gap >= PROGRAM_WAIT;
  endproperty
  a_verify_gap: assert property (p_verify_gap) else $error("verify too soon");
  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_take;
    !busy && start && programSupplyHigh && $past(programSupplyHigh)
      && $past(programSupplyHigh, 2) && $past(programSupplyHigh, 3) && !$past(rst, 3) |=> busy;
  endproperty
  a_take: assert property (p_take) else $error("start not taken");
  property p_refuse;
    !busy && !programSupplyHigh && !$past(programSupplyHigh)
      && !$past(programSupplyHigh, 2) && !$past(programSupplyHigh, 3) |=> !busy;
  endproperty
  a_refuse: assert property (p_refuse) else $error("start taken unpowered");
  property p_fail_clear;
    $fell(fail) |-> $past(start) && !$past(busy);
  endproperty
  a_fail_clear: assert property (p_fail_clear) else $error("fail dropped");
  c_ok: cover property (done && !fail);
  c_fail: cover property (done && fail);
  c_erase: cover property ($fell(bus.writeN) && bus.data == flash_seq_pkg::CMD_ERASE);
endmodule // flash_seq_properties
bind flash_command_sequencer flash_seq_properties #(
  .ADDR_W(ADDR_W), .PROGRAM_WAIT(PROGRAM_WAIT)
) i_props (
  .clk(clk), .rst(rst), .start(start), .op(op), .opAddr(opAddr), .opData(opData),
  .programSupplyHigh(programSupplyHigh), .dataLinesIn(dataLinesIn), .bus(bus),
  .busy(busy), .done(done), .fail(fail), .makerId(makerId), .partId(partId)
);

// ### tb/flash_device_model.sv
`timescale 1ns/1ps
module flash_device_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'hC3, // Arbitrary value
  parameter int         STOP_CYC   = 400    // Stop timer span, own choice
) (
  input  wire logic                      clk,
  input  wire logic                      supplyHigh,
  input  wire flash_seq_pkg::flash_bus_s bus,
  output logic [7:0]                     dataOut
);
  logic [7:0]  mem [4];
  logic [7:0]  rd;
  logic [7:0]  lastOut = 8'h00;
  logic [17:0] fallAddr, progAddr, verAddr;
  logic        prevW = 1'b1;
  int          mode = 0; // Read mode at power-up
  int          stopCnt = 0;
  int          progMiss = 0;
  int          eraseMiss = 0;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // Misses let the bench force retry loops
  task automatic eraseAll();
    if (eraseMiss > 0) eraseMiss--;
    else foreach (mem[i]) mem[i] = 8'hFF;
  endtask
  always @(posedge clk)
  begin
    // A pulse left running too long goes inactive until the next command
    stopCnt = (mode == 3 || mode == 6) ? stopCnt + 1 : 0;
    if (stopCnt > STOP_CYC) mode = 9;
    if (prevW && !bus.writeN) fallAddr = bus.addr;
    if (!prevW && bus.writeN && supplyHigh && !bus.chipSelN)
    begin
      if (mode == 5)
      begin
        progAddr = fallAddr;
        if (progMiss > 0) progMiss--;
        else mem[fallAddr[1:0]] &= bus.data;
        mode = 6;
      end
      else
        case (bus.data)
          8'h90: mode = 1;
          8'h20:
          begin
            if (mode == 2) eraseAll();
            mode = (mode == 2) ? 3 : 2;
          end
          8'hA0:
          begin
            verAddr = fallAddr;
            mode = 4;
          end
          8'h40: mode = 5;
          8'hC0: mode = 7;
          8'hFF: mode = (mode == 8) ? 0 : 8;
          default: mode = 0;
        endcase
    end
    if (!bus.chipSelN && !bus.outEnN) lastOut = rd;
    prevW = bus.writeN;
  end
  always_comb
  begin
    case (mode)
      1: rd = bus.addr[0] ? PART_CODE : MAKER_CODE;
      4: rd = mem[verAddr[1:0]];
      7: rd = mem[progAddr[1:0]];
      default: rd = mem[bus.addr[1:0]];
    endcase
  end
  // Released lines show a changed value, never the last one
  assign dataOut = (!bus.chipSelN && !bus.outEnN) ? rd : ~lastOut;
endmodule // flash_device_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      start = 1'b0;
  logic                      supply = 1'b0;
  flash_seq_pkg::op_e        op = flash_seq_pkg::OP_IDENT;
  logic [17:0]               opAddr = 18'h00000;
  logic [7:0]                opData = 8'h00;
  logic [7:0]                dataLines;
  flash_seq_pkg::flash_bus_s bus;
  logic                      busy, done, fail;
  logic [7:0]                makerId, partId;
  logic [15:0]               lfsr = 16'h9C85;
  int                        failures = 0;
  int                        cmp_count = 0;
  int                        expMem [4];
  logic                      expFail;
  flash_command_sequencer #(.ERASE_WAIT(50), .PROGRAM_WAIT(20), .LAST_ADDR(3)) i_dut (
    .clk(clk), .rst(rst), .start(start), .op(op), .opAddr(opAddr), .opData(opData),
    .programSupplyHigh(supply), .dataLinesIn(dataLines), .bus(bus), .busy(busy),
    .done(done), .fail(fail), .makerId(makerId), .partId(partId));
  flash_device_model i_dev (.clk(clk), .supplyHigh(supply), .bus(bus), .dataOut(dataLines));
  initial forever #2 clk = ~clk;
  ////////////////////////////////////////
  function automatic logic [15:0] nextRand(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chkBit(string what, logic exp, logic got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chkByte(string what, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(flash_seq_pkg::op_e o, logic [17:0] a, logic [7:0] d);
    int n;
    @(posedge clk) #1;
    op = o;
    opAddr = a;
    opData = d;
    start = 1'b1;
    @(posedge clk) #1;
    start = 1'b0;
    for (n = 0; n < 20000 && done !== 1'b1; n++) @(posedge clk) #1;
    chkBit("done", 1'b1, done);
  endtask
  task automatic results();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    failures++;
    results();
  end
  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    start = 1'b1;
    repeat (10) @(posedge clk) #1;
    chkBit("busy", 1'b0, busy);
    start = 1'b0;
    $display("test refuse finished");
    supply = 1'b1;
    repeat (4) @(posedge clk);
    run(flash_seq_pkg::OP_IDENT, 18'h00000, 8'h00);
    chkByte("makerId", i_dev.MAKER_CODE, makerId);
    chkByte("partId", i_dev.PART_CODE, partId);
    $display("test ident finished");
    i_dev.eraseMiss = 2;
    run(flash_seq_pkg::OP_ERASE, 18'h00000, 8'h00);
    chkBit("eraseFail", 1'b0, fail);
    foreach (expMem[i])
    begin
      expMem[i] = 255;
      chkByte("erased", 8'hFF, i_dev.mem[i]);
    end
    $display("test erase finished");
    for (int k = 0; k < 8; k++)
    begin
      lfsr = nextRand(lfsr);
      opAddr = {16'h0000, lfsr[1:0]};
      i_dev.progMiss = (k == 7) ? 30 : int'(lfsr[5:4]);
      expFail = ((expMem[lfsr[1:0]] & lfsr[15:8]) != lfsr[15:8]) || k == 7;
      if (k != 7) expMem[lfsr[1:0]] &= lfsr[15:8];
      run(flash_seq_pkg::OP_PROGRAM, {16'h0000, lfsr[1:0]}, lfsr[15:8]);
      chkBit("progFail", expFail, fail);
      chkByte("memByte", expMem[lfsr[1:0]][7:0], i_dev.mem[lfsr[1:0]]);
    end
    $display("test program finished");
    results();
  end
endmodule // tb_top
